// [include/pll_zd_defs.svh]
/*
 register offsets, field positions, reset values for the zero-delay
 control and pll status readback registers; assumes 10-bit addresses
*/
`ifndef PLL_ZD_DEFS_SVH
`define PLL_ZD_DEFS_SVH
`define ZD_CTRL_ADDR 10'h01E
`define PLL_STAT_ADDR 10'h01F
`define ZD_CTRL_RESET 8'h00
`define PLL_STAT_RESET 8'h00
`define ZD_CTRL_MASK 8'h1E
`define ZD_FB_SEL_LO 3
`define ZD_FB_SEL_HI 4
`define ZD_EXT_BIT 2
`define ZD_EN_BIT 1
`define STAT_CAL_DONE_BIT 6
`define STAT_HOLDOVER_BIT 5
`define STAT_ALT_REF_SEL_BIT 4
`define STAT_VCO_ABOVE_BIT 3
`define STAT_ALT_REF_ABOVE_BIT 2
`define STAT_MAIN_REF_ABOVE_BIT 1
`define STAT_LOCK_BIT 0
`endif

// [include/pll_zd_pkg.sv]
/*
 types for the zero-delay control and pll status register block;
 assumes nothing of its surroundings
*/
package pll_zd_pkg;
    typedef enum logic [1:0] {
        ZD_OFF = 2'b00,
        ZD_INTERNAL = 2'b01,
        ZD_EXTERNAL = 2'b10
    } zd_mode_t;
endpackage : pll_zd_pkg

// [rtl/pll_zd_status_regs.sv]
/*
 zero-delay control register and pll status readback register.
 assumes a serial port front end that presents decoded single-cycle
 write and read strobes with a 10-bit address, and status levels from
 the calibrator, holdover controller, reference monitors and lock
 detector, all synchronous to clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pll_zd_defs.svh"

module pll_zd_status_regs
    import pll_zd_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // register port
    input wire logic [9:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // status readback disable from control register 0x01D bit 4
    input wire logic status_freeze,
    // status sources
    input wire logic vco_cal_done,
    input wire logic holdover_active,
    input wire logic second_ref_selected,
    input wire logic vco_above_thresh,
    input wire logic second_ref_above_thresh,
    input wire logic first_ref_above_thresh,
    input wire logic pll_locked,
    // zero-delay controls
    output logic zd_enable,
    output logic zd_external,
    output var zd_mode_t zd_mode,
    output logic [1:0] zd_fb_select
);

    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] stat_reg;
    logic [7:0] stat_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic zd_en_reg;
    logic zd_en_next;
    logic zd_ext_reg;
    logic zd_ext_next;
    zd_mode_t mode_reg;
    zd_mode_t mode_next;
    logic [1:0] fb_reg;
    logic [1:0] fb_next;
    logic [7:0] stat_live;

    always_comb begin
        stat_live = 8'h00;
        stat_live[`STAT_CAL_DONE_BIT] = vco_cal_done;
        stat_live[`STAT_HOLDOVER_BIT] = holdover_active;
        stat_live[`STAT_ALT_REF_SEL_BIT] = second_ref_selected;
        stat_live[`STAT_VCO_ABOVE_BIT] = vco_above_thresh;
        stat_live[`STAT_ALT_REF_ABOVE_BIT] = second_ref_above_thresh;
        stat_live[`STAT_MAIN_REF_ABOVE_BIT] = first_ref_above_thresh;
        stat_live[`STAT_LOCK_BIT] = pll_locked;
    end

    always_comb begin
        ctrl_next = ctrl_reg;
        if (reg_wr && reg_addr == `ZD_CTRL_ADDR) begin
            ctrl_next = reg_wdata & `ZD_CTRL_MASK;
        end
        stat_next = status_freeze ? stat_reg : stat_live;
        rdata_next = rdata_reg;
        if (reg_rd) begin
            case (reg_addr)
                `ZD_CTRL_ADDR: rdata_next = ctrl_reg;
                `PLL_STAT_ADDR: rdata_next = stat_reg;
                default: rdata_next = 8'h00;
            endcase
        end
        zd_en_next = ctrl_next[`ZD_EN_BIT];
        zd_ext_next = ctrl_next[`ZD_EN_BIT] & ctrl_next[`ZD_EXT_BIT];
        fb_next = ctrl_next[`ZD_FB_SEL_HI:`ZD_FB_SEL_LO];
        case ({ctrl_next[`ZD_EN_BIT], ctrl_next[`ZD_EXT_BIT]})
            2'b10: mode_next = ZD_INTERNAL;
            2'b11: mode_next = ZD_EXTERNAL;
            default: mode_next = ZD_OFF;
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg <= `ZD_CTRL_RESET;
            stat_reg <= `PLL_STAT_RESET;
            rdata_reg <= 8'h00;
            zd_en_reg <= 1'b0;
            zd_ext_reg <= 1'b0;
            mode_reg <= ZD_OFF;
            fb_reg <= 2'b00;
        end else begin
            ctrl_reg <= ctrl_next;
            stat_reg <= stat_next;
            rdata_reg <= rdata_next;
            zd_en_reg <= zd_en_next;
            zd_ext_reg <= zd_ext_next;
            mode_reg <= mode_next;
            fb_reg <= fb_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign zd_enable = zd_en_reg;
    assign zd_external = zd_ext_reg;
    assign zd_mode = mode_reg;
    assign zd_fb_select = fb_reg;

    property p_zd_enable;
        @(posedge clk_sys) disable iff (sys_rst)
        (!sys_rst && reg_wr && reg_addr == `ZD_CTRL_ADDR)
            |=> zd_enable == $past(reg_wdata[`ZD_EN_BIT]);
    endproperty
    a_zd_enable: assert property (p_zd_enable)
        else $error("zd enable wrong");

    property p_zd_mode;
        @(posedge clk_sys) disable iff (sys_rst)
        zd_external |-> (zd_enable && zd_mode == ZD_EXTERNAL);
    endproperty
    a_zd_mode: assert property (p_zd_mode)
        else $error("zd mode wrong");

    property p_ext_mode;
        @(posedge clk_sys) disable iff (sys_rst)
        zd_external == (ctrl_reg[`ZD_EN_BIT] && ctrl_reg[`ZD_EXT_BIT]);
    endproperty
    a_ext_mode: assert property (p_ext_mode)
        else $error("external mode does not follow control bits");

    property p_int_mode;
        @(posedge clk_sys) disable iff (sys_rst)
        (zd_enable && !zd_external) |-> zd_mode == ZD_INTERNAL;
    endproperty
    a_int_mode: assert property (p_int_mode)
        else $error("internal mode not selected");

    property p_zd_off;
        @(posedge clk_sys) disable iff (sys_rst)
        !zd_enable |-> (zd_mode == ZD_OFF && !zd_external);
    endproperty
    a_zd_off: assert property (p_zd_off)
        else $error("zero delay active while disabled");

    property p_ctrl_write;
        @(posedge clk_sys) disable iff (sys_rst)
        (!sys_rst && reg_wr && reg_addr == `ZD_CTRL_ADDR)
            |=> ctrl_reg == ($past(reg_wdata) & `ZD_CTRL_MASK);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("control write not stored as masked");

    property p_ctrl_hold;
        @(posedge clk_sys) disable iff (sys_rst)
        (!sys_rst && !(reg_wr && reg_addr == `ZD_CTRL_ADDR))
            |=> $stable(ctrl_reg);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold)
        else $error("control changed without a write to it");

    property p_ctrl_read;
        @(posedge clk_sys) disable iff (sys_rst)
        (!sys_rst && reg_rd && reg_addr == `ZD_CTRL_ADDR)
            |=> reg_rdata == $past(ctrl_reg);
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("control misread");

    property p_unmapped_read;
        @(posedge clk_sys) disable iff (sys_rst)
        (!sys_rst && reg_rd && reg_addr != `ZD_CTRL_ADDR
            && reg_addr != `PLL_STAT_ADDR) |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read not zero");

    property p_freeze;
        @(posedge clk_sys) disable iff (sys_rst)
        status_freeze |=> $stable(stat_reg);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("status moved while frozen");

    property p_refresh;
        @(posedge clk_sys) disable iff (sys_rst)
        (!sys_rst && !status_freeze) |=> stat_reg == $past(stat_live);
    endproperty
    a_refresh: assert property (p_refresh)
        else $error("status not refreshed");

    property p_lock_read;
        @(posedge clk_sys) disable iff (sys_rst)
        (reg_rd && reg_addr == `PLL_STAT_ADDR)
            |=> reg_rdata[0] == $past(stat_reg[0]);
    endproperty
    a_lock_read: assert property (p_lock_read)
        else $error("lock bit misread");

    property p_cal_read;
        @(posedge clk_sys) disable iff (sys_rst)
        (!sys_rst && !status_freeze ##1 reg_rd && reg_addr == `PLL_STAT_ADDR)
            |=> reg_rdata[6] == $past(vco_cal_done, 2);
    endproperty
    a_cal_read: assert property (p_cal_read)
        else $error("cal bit misread");

    property p_hold;
        @(posedge clk_sys) disable iff (sys_rst)
        (!sys_rst && !status_freeze)
            |=> stat_reg[5:4] == $past({holdover_active, second_ref_selected});
    endproperty
    a_hold: assert property (p_hold)
        else $error("holdover or ref select wrong");

    property p_freq;
        @(posedge clk_sys) disable iff (sys_rst)
        (!sys_rst && !status_freeze) |=> stat_reg[3:1] == $past({
            vco_above_thresh, second_ref_above_thresh, first_ref_above_thresh});
    endproperty
    a_freq: assert property (p_freq)
        else $error("frequency flags wrong");

    property p_unused;
        @(posedge clk_sys) disable iff (sys_rst)
        reg_rdata[7] == 1'b0 && ctrl_reg[0] == 1'b0 && ctrl_reg[7:5] == 3'b000;
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused bit set");

endmodule : pll_zd_status_regs

`default_nettype wire

// [test/pll_zd_status_regs_test.sv]
/*
 bench for the zero-delay control and pll status registers;
 assumes the decoded one-cycle strobe register port of the design
*/
`timescale 1ns/100ps
`default_nettype none
module pll_zd_status_regs_test;
    import pll_zd_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [9:0] reg_addr = 10'h000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic status_freeze = 1'b0;
    logic [6:0] src = 7'h00;
    logic zd_enable;
    logic zd_external;
    zd_mode_t zd_mode;
    logic [1:0] zd_fb_select;
    logic [7:0] rd;
    int num_errors = 0;
    int n_tests = 0;
    always #10 clk_sys = ~clk_sys;
    pll_zd_status_regs pll_zd_status_regs_i (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .status_freeze(status_freeze), .vco_cal_done(src[6]),
        .holdover_active(src[5]), .second_ref_selected(src[4]),
        .vco_above_thresh(src[3]), .second_ref_above_thresh(src[2]),
        .first_ref_above_thresh(src[1]), .pll_locked(src[0]),
        .zd_enable(zd_enable), .zd_external(zd_external),
        .zd_mode(zd_mode), .zd_fb_select(zd_fb_select));
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic reg_write(logic [9:0] a, logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask : reg_write
    task automatic reg_read(logic [9:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask : reg_read
    function automatic logic [7:0] outs();
        return {2'b00, zd_enable, zd_external, zd_mode, zd_fb_select};
    endfunction : outs
    task automatic test_modes();
        logic [7:0] wv [4] = '{8'hFF, 8'h02, 8'h04, 8'h0A};
        logic [7:0] rv [4] = '{8'h1E, 8'h02, 8'h04, 8'h0A};
        logic [7:0] ov [4] = '{8'h3B, 8'h24, 8'h00, 8'h25};
        reg_read(10'h01E);
        check("ctrl reset", 8'h00, rd);
        check("outs reset", 8'h00, outs());
        for (int i = 0; i < 4; i++) begin
            reg_write(10'h01E, wv[i]);
            check("zd outputs", ov[i], outs());
            reg_read(10'h01E);
            check("ctrl read", rv[i], rd);
        end
        $display("test_modes done");
    endtask : test_modes
    task automatic test_status();
        logic [7:0] e;
        for (int i = 0; i < 8; i++) begin
            e = (i == 7) ? 8'h7F : 8'(1 << i);
            @(posedge clk_sys);
            src <= e[6:0];
            reg_read(10'h01F);
            check("stat", e, rd);
        end
        $display("test_status done");
    endtask : test_status
    task automatic test_refused();
        @(posedge clk_sys);
        src <= 7'h00;
        @(posedge clk_sys);
        status_freeze <= 1'b1;
        reg_write(10'h01F, 8'hFF);
        reg_read(10'h01F);
        check("status write", 8'h00, rd);
        @(posedge clk_sys);
        status_freeze <= 1'b0;
        reg_write(10'h11E, 8'h00);
        reg_read(10'h01E);
        check("ctrl alias", 8'h0A, rd);
        reg_read(10'h100);
        check("unmapped", 8'h00, rd);
        $display("test_refused done");
    endtask : test_refused
    task automatic test_freeze();
        @(posedge clk_sys);
        src <= 7'h55;
        @(posedge clk_sys);
        @(posedge clk_sys);
        status_freeze <= 1'b1;
        src <= 7'h2A;
        reg_read(10'h01F);
        check("frozen", 8'h55, rd);
        @(posedge clk_sys);
        status_freeze <= 1'b0;
        reg_read(10'h01F);
        check("refreshed", 8'h2A, rd);
        $display("test_freeze done");
    endtask : test_freeze
    task automatic test_reset();
        @(posedge clk_sys);
        src <= 7'h7F;
        reg_write(10'h01E, 8'h1E);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        check("outs in reset", 8'h00, outs());
        check("rdata in reset", 8'h00, reg_rdata);
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        reg_read(10'h01E);
        check("ctrl after reset", 8'h00, rd);
        reg_read(10'h01F);
        check("status after reset", 8'h7F, rd);
        $display("test_reset done");
    endtask : test_reset
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        test_modes();
        test_status();
        test_refused();
        test_freeze();
        test_reset();
        print_verdict();
    end
    initial begin
        #100000;
        num_errors++;
        print_verdict();
    end
endmodule : pll_zd_status_regs_test
`default_nettype wire
